// ===== shared/mtsc_pkg.sv
// Package for the transmit statistics counter bank.
// Assumes a register read port decoded to word indices.
`default_nettype none
package mtsc_pkg;
  // Register indices in the MAC register space
  localparam logic [15:0] ADDR_LARGE_OK = 16'h003a;
  localparam logic [15:0] ADDR_UNDERFLOW = 16'h003b;
  localparam logic [15:0] ADDR_ONE_COL = 16'h003c;
  localparam logic [15:0] ADDR_MANY_COL = 16'h003d;
  // Field widths
  localparam int LARGE_W = 32;
  localparam int UFLOW_W = 10;
  localparam int COL_W = 18;
  // Saturation ceilings
  localparam logic [31:0] LARGE_MAX = 32'h0fffffff;
  localparam logic [9:0] UFLOW_MAX = 10'h3ff;
  localparam logic [17:0] COL_MAX = 18'h3ffff;
  // Frame size threshold in bytes
  localparam logic [15:0] LARGE_BYTES = 16'h0400;
  // Reset value of every counter
  localparam logic [31:0] CNT_RESET = 32'h00000000;
endpackage
`default_nettype wire

// ===== verilog/mtsc_counters.sv
// Four clear-on-read saturating transmit statistics counters.
// Assumes event pulses are one cycle wide and synchronous to REF_CLK.
`default_nettype none

module mtsc_counters
  import mtsc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register read port
  input wire logic RD_EN,
  input wire logic [15:0] RD_ADDR,
  output logic [31:0] RD_DATA,
  output logic RD_VALID,
  // Transmit path events
  input wire logic TX_DONE_OK,
  input wire logic [15:0] TX_FRAME_BYTES,
  input wire logic [4:0] TX_COLLISIONS,
  input wire logic TX_UNDERFLOW_ABORT,
  input wire logic CUT_THROUGH_EN,
  // PLCA reconciliation sublayer
  input wire logic PLCA_EN,
  input wire logic PLCA_LOGICAL_COL
);

  logic [31:0] large_cnt, next_large_cnt;
  logic [9:0] uflow_cnt, next_uflow_cnt;
  logic [17:0] one_cnt, next_one_cnt;
  logic [17:0] many_cnt, next_many_cnt;
  logic [31:0] next_rd_data;
  logic next_rd_valid;
  logic ev_large, ev_uflow, ev_one, ev_many;
  logic rd_large, rd_uflow, rd_one, rd_many;
  logic one_col_frame;

  // Read address decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = RD_EN && (a == r);
  endfunction

  // Event qualification
  always_comb begin
    ev_large = TX_DONE_OK && (TX_FRAME_BYTES >= LARGE_BYTES);
    ev_uflow = TX_UNDERFLOW_ABORT && CUT_THROUGH_EN;
    // Under PLCA the RS reports one logical collision per frame
    one_col_frame = PLCA_EN ? PLCA_LOGICAL_COL
                            : (TX_COLLISIONS == 5'h01);
    ev_one = TX_DONE_OK && one_col_frame;
    // Counted regardless of PLCA so misconfiguration shows up
    ev_many = TX_DONE_OK && (TX_COLLISIONS > 5'h01);
    rd_large = hit(RD_ADDR, ADDR_LARGE_OK);
    rd_uflow = hit(RD_ADDR, ADDR_UNDERFLOW);
    rd_one = hit(RD_ADDR, ADDR_ONE_COL);
    rd_many = hit(RD_ADDR, ADDR_MANY_COL);
  end

  // Next counter values: clear on read, event survives the clear
  always_comb begin
    // Large frames: clear on read, else saturating increment
    next_large_cnt = large_cnt;
    if (rd_large) begin
      next_large_cnt = {31'h0, ev_large};
    end else if (ev_large && large_cnt != LARGE_MAX) begin
      next_large_cnt = large_cnt + 32'h1;
    end
    // Underflow aborts, 10-bit field
    next_uflow_cnt = uflow_cnt;
    if (rd_uflow) begin
      next_uflow_cnt = {9'h0, ev_uflow};
    end else if (ev_uflow && uflow_cnt != UFLOW_MAX) begin
      next_uflow_cnt = uflow_cnt + 10'h1;
    end
    // Single-collision frames, 18-bit field
    next_one_cnt = one_cnt;
    if (rd_one) begin
      next_one_cnt = {17'h0, ev_one};
    end else if (ev_one && one_cnt != COL_MAX) begin
      next_one_cnt = one_cnt + 18'h1;
    end
    // Multiple-collision frames, 18-bit field
    next_many_cnt = many_cnt;
    if (rd_many) begin
      next_many_cnt = {17'h0, ev_many};
    end else if (ev_many && many_cnt != COL_MAX) begin
      next_many_cnt = many_cnt + 18'h1;
    end
  end

  // Read data mux, unused upper bits zero
  always_comb begin
    next_rd_valid = RD_EN;
    next_rd_data = CNT_RESET;
    if (rd_large) begin
      next_rd_data = large_cnt;
    end else if (rd_uflow) begin
      next_rd_data = {22'h0, uflow_cnt};
    end else if (rd_one) begin
      next_rd_data = {14'h0, one_cnt};
    end else if (rd_many) begin
      next_rd_data = {14'h0, many_cnt};
    end
  end

  // State registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      large_cnt <= CNT_RESET;
      uflow_cnt <= CNT_RESET[UFLOW_W-1:0];
      one_cnt <= CNT_RESET[COL_W-1:0];
      many_cnt <= CNT_RESET[COL_W-1:0];
      RD_DATA <= CNT_RESET;
      RD_VALID <= 1'b0;
    end else begin
      large_cnt <= next_large_cnt;
      uflow_cnt <= next_uflow_cnt;
      one_cnt <= next_one_cnt;
      many_cnt <= next_many_cnt;
      RD_DATA <= next_rd_data;
      RD_VALID <= next_rd_valid;
    end
  end

  // Assertions
  // A read is a decoded request followed by the registered answer
  sequence s_read_large;
    rd_large ##1 RD_VALID;
  endsequence

  sequence s_read_uflow;
    rd_uflow ##1 RD_VALID;
  endsequence

  sequence s_read_one;
    rd_one ##1 RD_VALID;
  endsequence

  sequence s_read_many;
    rd_many ##1 RD_VALID;
  endsequence

  property p_large_count;
    @(posedge REF_CLK) disable iff (!RST_N)
      ev_large && !rd_large && large_cnt != LARGE_MAX
      |=> large_cnt == $past(large_cnt) + 32'h1;
  endproperty
  a_large_count: assert property (p_large_count)
    else $error("large counter missed event");

  property p_large_sat;
    @(posedge REF_CLK) disable iff (!RST_N)
      large_cnt == LARGE_MAX && !rd_large |=> large_cnt == LARGE_MAX;
  endproperty
  a_large_sat: assert property (p_large_sat)
    else $error("large counter wrapped");

  property p_large_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      s_read_large |-> RD_DATA == $past(large_cnt)
        && large_cnt == {31'h0, $past(ev_large)};
  endproperty
  a_large_read: assert property (p_large_read)
    else $error("large read value or clear wrong");

  property p_uflow_upper;
    @(posedge REF_CLK) disable iff (!RST_N)
      $past(rd_uflow) |-> RD_VALID && RD_DATA[31:10] == 22'h0;
  endproperty
  a_uflow_upper: assert property (p_uflow_upper)
    else $error("underflow upper bits nonzero");

  property p_uflow_sf;
    @(posedge REF_CLK) disable iff (!RST_N)
      !CUT_THROUGH_EN && !rd_uflow |=> uflow_cnt == $past(uflow_cnt);
  endproperty
  a_uflow_sf: assert property (p_uflow_sf)
    else $error("underflow counted in store and forward");

  property p_uflow_sat;
    @(posedge REF_CLK) disable iff (!RST_N)
      uflow_cnt == UFLOW_MAX && !rd_uflow |=> uflow_cnt == UFLOW_MAX;
  endproperty
  a_uflow_sat: assert property (p_uflow_sat)
    else $error("underflow counter wrapped");

  property p_one_count;
    @(posedge REF_CLK) disable iff (!RST_N)
      TX_DONE_OK && !PLCA_EN && TX_COLLISIONS == 5'h01 && !rd_one
      && one_cnt != COL_MAX |=> one_cnt == $past(one_cnt) + 18'h1;
  endproperty
  a_one_count: assert property (p_one_count)
    else $error("single collision not counted");

  property p_one_plca;
    @(posedge REF_CLK) disable iff (!RST_N)
      PLCA_EN && !PLCA_LOGICAL_COL && !rd_one
      |=> one_cnt == $past(one_cnt);
  endproperty
  a_one_plca: assert property (p_one_plca)
    else $error("single collision counted without logical collision");

  property p_many_count;
    @(posedge REF_CLK) disable iff (!RST_N)
      TX_DONE_OK && TX_COLLISIONS > 5'h01 && !rd_many
      && many_cnt != COL_MAX |=> many_cnt == $past(many_cnt) + 18'h1;
  endproperty
  a_many_count: assert property (p_many_count)
    else $error("multiple collision not counted");

  property p_many_plca;
    @(posedge REF_CLK) disable iff (!RST_N)
      PLCA_EN && TX_DONE_OK && TX_COLLISIONS > 5'h01 && !rd_many
      && many_cnt != COL_MAX |=> many_cnt != $past(many_cnt);
  endproperty
  a_many_plca: assert property (p_many_plca)
    else $error("multiple collision hidden under plca");

  property p_col_sat;
    @(posedge REF_CLK) disable iff (!RST_N)
      one_cnt == COL_MAX && !rd_one |=> one_cnt == COL_MAX;
  endproperty
  a_col_sat: assert property (p_col_sat)
    else $error("collision counter wrapped");

  property p_many_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      s_read_many |-> RD_DATA == {14'h0, $past(many_cnt)}
        && many_cnt == {17'h0, $past(ev_many)};
  endproperty
  a_many_read: assert property (p_many_read)
    else $error("multiple collision read wrong");

  property p_many_sat;
    @(posedge REF_CLK) disable iff (!RST_N)
      many_cnt == COL_MAX && !rd_many |=> many_cnt == COL_MAX;
  endproperty
  a_many_sat: assert property (p_many_sat)
    else $error("multiple collision counter wrapped");

  // Count and read-clear checks on the other counters
  property p_uflow_count;
    @(posedge REF_CLK) disable iff (!RST_N)
      TX_UNDERFLOW_ABORT && CUT_THROUGH_EN && !rd_uflow
      && uflow_cnt != UFLOW_MAX |=> uflow_cnt == $past(uflow_cnt) + 10'h1;
  endproperty
  a_uflow_count: assert property (p_uflow_count)
    else $error("underflow abort not counted");

  property p_uflow_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      s_read_uflow |-> RD_DATA[9:0] == $past(uflow_cnt)
        && uflow_cnt == {9'h0, $past(TX_UNDERFLOW_ABORT && CUT_THROUGH_EN)};
  endproperty
  a_uflow_read: assert property (p_uflow_read)
    else $error("underflow read value or clear wrong");

  property p_one_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      s_read_one |-> RD_DATA == {14'h0, $past(one_cnt)}
        && one_cnt == {17'h0, $past(ev_one)};
  endproperty
  a_one_read: assert property (p_one_read)
    else $error("single collision read value or clear wrong");

  // Counters hold when nothing qualifies and nothing reads
  property p_large_small;
    @(posedge REF_CLK) disable iff (!RST_N)
      TX_DONE_OK && TX_FRAME_BYTES < LARGE_BYTES && !rd_large
      |=> large_cnt == $past(large_cnt);
  endproperty
  a_large_small: assert property (p_large_small)
    else $error("short frame counted as large");

  property p_large_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      !TX_DONE_OK && !rd_large |=> large_cnt == $past(large_cnt);
  endproperty
  a_large_hold: assert property (p_large_hold)
    else $error("large counter moved without a frame");

  property p_one_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      !TX_DONE_OK && !rd_one |=> one_cnt == $past(one_cnt);
  endproperty
  a_one_hold: assert property (p_one_hold)
    else $error("single collision counter moved without a frame");

  property p_many_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      !TX_DONE_OK && !rd_many |=> many_cnt == $past(many_cnt);
  endproperty
  a_many_hold: assert property (p_many_hold)
    else $error("multiple collision counter moved without a frame");

endmodule
`default_nettype wire

// ===== test/mtsc_host.sv
// Host model that reads the statistic registers.
// Assumes each call starts just after a falling clock edge.
`default_nettype none
module mtsc_host (
  // Clock and answer
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  // Request
  output logic rd_en,
  output logic [15:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_en = 1'h0;
    rd_addr = 16'h0000;
  end
  // One-cycle request; the answer must stand exactly one cycle later
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    rd_en = 1'h1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'h0;
    rd_addr = ~a; // Released index no longer shows the old value
    d = (rd_valid === 1'h1) ? rd_data : 'x;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== test/mac_tx_statistics_counters_tb.sv
// Testbench for the transmit statistics counters.
// Assumes the host model drives the read port.
`default_nettype none
module mac_tx_statistics_counters_tb;
  import mtsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, rd_en, rd_valid, ok, uf, ct, pe, lc;
  logic [15:0] rd_addr, by;
  logic [31:0] rd_data;
  logic [4:0] co;
  logic [31:0] d;
  int fails, checks_done;
  mtsc_counters mtsc_counters_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .TX_DONE_OK(ok), .TX_FRAME_BYTES(by),
    .TX_COLLISIONS(co), .TX_UNDERFLOW_ABORT(uf), .CUT_THROUGH_EN(ct),
    .PLCA_EN(pe), .PLCA_LOGICAL_COL(lc));
  mtsc_host mtsc_host_i (.clk(ref_clk), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr));
  // Clock of 4 ns
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // One cycle of transmit events
  task automatic ev(input logic o, input logic [15:0] b,
      input logic [4:0] c, input logic l, input logic u);
    ok = o;
    by = b;
    co = c;
    lc = l;
    uf = u;
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    mtsc_host_i.rd(a, d);
    chk(d, exp);
  endtask
  // Counters return to zero on a mid-run reset
  task automatic t_reset();
    rdc(ADDR_ONE_COL, 32'h00000000);
    ev(1'h1, LARGE_BYTES, 5'h01, 1'h0, 1'h0);
    ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
    rst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    rdc(ADDR_LARGE_OK, 32'h00000000);
    rdc(ADDR_ONE_COL, 32'h00000000);
    $display("reset done");
  endtask
  task automatic t_large();
    ev(1'h1, 16'h03ff, 5'h00, 1'h0, 1'h0);
    ev(1'h1, LARGE_BYTES, 5'h00, 1'h0, 1'h0);
    ev(1'h1, 16'hffff, 5'h00, 1'h0, 1'h0);
    ev(1'h0, 16'hffff, 5'h00, 1'h0, 1'h0);
    ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
    rdc(16'h0040, 32'h00000000);
    rdc(ADDR_LARGE_OK, 32'h00000002);
    rdc(ADDR_LARGE_OK, 32'h00000000);
    $display("large frames done");
  endtask
  task automatic t_uflow();
    repeat (3) ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h1);
    ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
    rdc(ADDR_UNDERFLOW, 32'h00000000);
    ct = 1'h1;
    repeat (1025) ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h1);
    ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
    rdc(ADDR_UNDERFLOW, 32'h000003ff);
    rdc(ADDR_UNDERFLOW, 32'h00000000);
    $display("underflow done");
  endtask
  task automatic t_col();
    ev(1'h1, 16'h0040, 5'h01, 1'h0, 1'h0);
    ev(1'h1, 16'h0040, 5'h02, 1'h1, 1'h0);
    ev(1'h1, 16'h0040, 5'h1f, 1'h0, 1'h0);
    ev(1'h0, 16'h0040, 5'h01, 1'h0, 1'h0);
    pe = 1'h1;
    ev(1'h1, 16'h0040, 5'h01, 1'h0, 1'h0);
    ev(1'h1, 16'h0040, 5'h00, 1'h1, 1'h0);
    ev(1'h1, 16'h0040, 5'h03, 1'h0, 1'h0);
    ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
    rdc(ADDR_ONE_COL, 32'h00000002);
    rdc(ADDR_MANY_COL, 32'h00000003);
    rdc(ADDR_MANY_COL, 32'h00000000);
    $display("collisions done");
  endtask
  // Read of a counter in the very cycle of a counted event
  task automatic t_race();
    ev(1'h1, 16'h0040, 5'h00, 1'h1, 1'h0);
    fork
      mtsc_host_i.rd(ADDR_ONE_COL, d);
      begin
        ev(1'h1, 16'h0040, 5'h00, 1'h1, 1'h0);
        ev(1'h0, 16'h0000, 5'h00, 1'h0, 1'h0);
      end
    join
    chk(d, 32'h00000001);
    rdc(ADDR_ONE_COL, 32'h00000001);
    rdc(ADDR_ONE_COL, 32'h00000000);
    $display("read race done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    rst_n = 1'h0;
    ct = 1'h0;
    pe = 1'h0;
    {ok, uf, lc, by, co} = '0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    t_reset();
    t_large();
    t_uflow();
    t_col();
    t_race();
    end_of_test();
  end
  // Watchdog, well beyond about 1100 cycles of tests
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
